// ### common/sram_burst_pkg.sv
// Purpose: shared widths, counts and carriers for the burst-4 read port
// Assumes: x36 organisation by default
// Notes: the x8/x9 and x18 organisations use 19 and 18 address bits
package sram_burst_pkg;
    localparam int DATA_W = 36;
    localparam int ADDR_W = 17;
    localparam int BURST_LEN = 4;
    localparam int N_SLOTS = 2;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0_0000;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [1:0] SYNC_RST = 2'h0;

    typedef logic [DATA_W-1:0] word_t;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef word_t [BURST_LEN-1:0] burst_words_t;

    typedef struct packed {
        addr_t addr;
        burst_words_t words;
    } burst_t;

    typedef struct packed {
        logic rise_v;
        word_t rise_w;
        logic fall_v;
        word_t fall_w;
    } ddr_pair_t;

    typedef enum logic [2:0] {ph_idle, ph_1, ph_2, ph_3, ph_4} slot_ph_t;
    typedef enum logic [1:0] {wr_idle, wr_1, wr_2} wr_ph_t;
endpackage

// ### design/burst4_sram_read_port.sv
// Purpose: read port, shared address bus and echo clocks of a burst-4 DDR SRAM
// Assumes: pins are synchronous to k_clk_i; complementary clock taken as its falling edge
// Notes: user preload port on sys_clk_i; read wins over a write on the same edge
// Operation
// [R01] one shared address bus, sampled on true clock rise
// [R02] four arrays, one address selects four words
// [R03] address ignored when its port is deselected
// [R04] read words launched on both clock phases
// [R05] read outputs tristated while read port idle
// [R06] read select low on true rise starts read
// [R07] deselect finishes pending read, then tristates
// [R08] each read returns four sequential words
// [R09] valid flag high exactly while data valid
// [R10] accesses begin only on true clock rise
// [R11] inputs captured and data launched on complementary clock
// [R12] echo clock pair runs continuously, locked to clock
// [R13] write select low starts write, else data ignored
// [R14] pll disabled selects one-cycle read latency
// [R15] pll enabled: first word 2.5 cycles later
`timescale 1ns/10ps
module burst4_sram_read_port
    import sram_burst_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic k_clk_i,
    input wire addr_t address_i,
    input wire logic read_select_n_i,
    input wire logic write_select_n_i,
    input wire word_t write_data_i,
    input wire logic pll_disable_n_i,
    input wire logic load_valid_i,
    input wire burst_t load_data_i,
    output logic load_ready_o,
    output logic burst_active_o,
    output word_t read_data_o,
    output logic read_data_oe_o,
    output logic read_valid_flag_o,
    output logic echo_strobe_o,
    output logic echo_strobe_inverse_o
);
    logic k_rst_meta;
    logic k_rst_n;
    logic pll_meta;
    logic pll_on;
    logic rd_gap;
    logic rd_take;
    logic wr_take;
    logic slot_sel;
    slot_ph_t slot_ph [N_SLOTS];
    addr_t slot_addr [N_SLOTS];
    burst_words_t slot_buf [N_SLOTS];
    addr_t fetch_addr;
    burst_words_t fetch_words;
    ddr_pair_t next_pair;
    wr_ph_t wr_ph;
    addr_t wr_addr;
    word_t wbuf0;
    word_t d_neg;
    logic cm_pend;
    addr_t cm_addr;
    word_t [2:0] cm_words;
    logic ld_valid;
    logic ld_take;
    burst_t ld_data;
    logic mem_we;
    addr_t mem_waddr;
    burst_words_t mem_wdata;
    logic [3:0] ctrl_rise;
    logic [3:0] ctrl_fall;
    logic [3:0] ctrl_q;
    logic k_active;
    logic act_meta;

    // link-side reset: asserted at once, released on the link clock
    always_ff @(posedge k_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            k_rst_meta <= 1'b0;
            k_rst_n <= 1'b0;
        end else begin
            k_rst_meta <= 1'b1;
            k_rst_n <= k_rst_meta;
        end
    end

    // static mode strap, brought onto the link clock
    always_ff @(posedge k_clk_i or negedge k_rst_n) begin
        if (!k_rst_n) begin
            pll_meta <= 1'b1;
            pll_on <= 1'b1;
        end else begin
            pll_meta <= pll_disable_n_i;
            pll_on <= pll_meta; // [R14]
        end
    end

    // read request taken on the true clock rise, one burst per two edges
    assign rd_take = !read_select_n_i && !rd_gap; // [R06] [R10]

    always_ff @(posedge k_clk_i or negedge k_rst_n) begin
        if (!k_rst_n) begin
            rd_gap <= 1'b0;
            slot_sel <= 1'b0;
        end else begin
            rd_gap <= rd_take;
            if (rd_take) begin
                slot_sel <= ~slot_sel;
            end
        end
    end

    // two burst slots so consecutive reads may overlap
    for (genvar s = 0; s < N_SLOTS; s++) begin : gen_slot
        always_ff @(posedge k_clk_i or negedge k_rst_n) begin
            if (!k_rst_n) begin
                slot_ph[s] <= ph_idle;
                slot_addr[s] <= ADDR_RST;
            end else if (rd_take && (slot_sel == 1'(s))) begin
                slot_ph[s] <= ph_1;
                slot_addr[s] <= address_i; // [R01] [R03]
            end else begin
                case (slot_ph[s])
                    ph_1: slot_ph[s] <= ph_2;
                    ph_2: slot_ph[s] <= pll_on ? ph_3 : ph_idle; // [R14]
                    ph_3: slot_ph[s] <= ph_4;
                    ph_4: slot_ph[s] <= ph_idle;
                    default: slot_ph[s] <= ph_idle;
                endcase
            end
        end

        always_ff @(posedge k_clk_i or negedge k_rst_n) begin
            if (!k_rst_n) begin
                slot_buf[s] <= '0;
            end else if (slot_ph[s] == ph_1) begin
                slot_buf[s] <= fetch_words;
            end
        end
    end

    always_comb begin
        fetch_addr = ADDR_RST;
        for (int i = 0; i < N_SLOTS; i++) begin
            if (slot_ph[i] == ph_1) begin
                fetch_addr = slot_addr[i];
            end
        end
    end

    // four arrays, one word each per address
    for (genvar g = 0; g < BURST_LEN; g++) begin : gen_lane
        word_t lane [MEM_DEPTH]; // [R02]

        always_ff @(posedge k_clk_i) begin
            if (mem_we) begin
                lane[mem_waddr] <= mem_wdata[g];
            end
        end

        assign fetch_words[g] = lane[fetch_addr];
    end

    // words a slot places on each half of the coming cycle
    function automatic ddr_pair_t slot_pair(input slot_ph_t ph, input logic pll,
                                            input burst_words_t w);
        ddr_pair_t p;
        p = '0;
        if (pll) begin
            case (ph)
                ph_2: begin
                    p.fall_v = 1'b1;
                    p.fall_w = w[0]; // [R15]
                end
                ph_3: begin
                    p.rise_v = 1'b1;
                    p.rise_w = w[1];
                    p.fall_v = 1'b1;
                    p.fall_w = w[2];
                end
                ph_4: begin
                    p.rise_v = 1'b1;
                    p.rise_w = w[3];
                end
                default: p = '0;
            endcase
        end else begin
            case (ph)
                ph_1: begin
                    p.rise_v = 1'b1;
                    p.rise_w = w[0];
                    p.fall_v = 1'b1;
                    p.fall_w = w[1];
                end
                ph_2: begin
                    p.rise_v = 1'b1;
                    p.rise_w = w[2];
                    p.fall_v = 1'b1;
                    p.fall_w = w[3];
                end
                default: p = '0;
            endcase
        end
        return p;
    endfunction

    // sequential burst order, slots merged; idle halves carry zero
    always_comb begin
        next_pair = '0;
        for (int i = 0; i < N_SLOTS; i++) begin
            next_pair = next_pair | slot_pair(slot_ph[i], pll_on,
                (slot_ph[i] == ph_1) ? fetch_words : slot_buf[i]); // [R08]
        end
    end

    // write request: read wins when both are selected on one edge
    assign wr_take = !write_select_n_i && !rd_take && (wr_ph != wr_1); // [R13] [R10]

    // second word of each write pair arrives on the complementary edge
    always_ff @(negedge k_clk_i or negedge k_rst_n) begin
        if (!k_rst_n) begin
            d_neg <= DATA_RST;
        end else begin
            d_neg <= write_data_i; // [R11]
        end
    end

    always_ff @(posedge k_clk_i or negedge k_rst_n) begin
        if (!k_rst_n) begin
            wr_ph <= wr_idle;
            wr_addr <= ADDR_RST;
            wbuf0 <= DATA_RST;
        end else begin
            case (wr_ph)
                wr_1: begin
                    wbuf0 <= write_data_i;
                    wr_ph <= wr_2;
                end
                default: wr_ph <= wr_idle;
            endcase
            if (wr_take) begin
                wr_ph <= wr_1;
                wr_addr <= address_i; // [R01] [R03]
            end
        end
    end

    always_ff @(posedge k_clk_i or negedge k_rst_n) begin
        if (!k_rst_n) begin
            cm_pend <= 1'b0;
            cm_addr <= ADDR_RST;
            cm_words <= '0;
        end else begin
            cm_pend <= (wr_ph == wr_2);
            if (wr_ph == wr_2) begin
                cm_addr <= wr_addr;
                cm_words <= {write_data_i, d_neg, wbuf0};
            end
        end
    end

    // preload bursts from the user clock
    load_crossing u_load (
        .src_clk_i(sys_clk_i),
        .src_rst_n_i(rst_n_i),
        .src_valid_i(load_valid_i),
        .src_data_i(load_data_i),
        .src_ready_o(load_ready_o),
        .dst_clk_i(k_clk_i),
        .dst_rst_n_i(k_rst_n),
        .dst_take_i(ld_take),
        .dst_valid_o(ld_valid),
        .dst_data_o(ld_data)
    );

    // pin writes have priority over preload
    assign ld_take = ld_valid && !cm_pend;
    assign mem_we = cm_pend || ld_take;
    assign mem_waddr = cm_pend ? cm_addr : ld_data.addr;
    assign mem_wdata = cm_pend ? {d_neg, cm_words} : ld_data.words;

    // read data pair: launched on both halves of the clock
    ddr_out_cell #(
        .WIDTH(DATA_W)
    ) u_data (
        .clk_i(k_clk_i),
        .rst_n_i(k_rst_n),
        .rise_i(next_pair.rise_w),
        .fall_i(next_pair.fall_w),
        .q_o(read_data_o)
    ); // [R04] [R11]

    // drive enable, valid flag and echo pair share one launch register
    assign ctrl_rise = {next_pair.rise_v, next_pair.rise_v, 1'b1, 1'b0}; // [R05] [R07]
    assign ctrl_fall = {next_pair.fall_v, next_pair.fall_v, 1'b0, 1'b1}; // [R09] [R12]

    ddr_out_cell #(
        .WIDTH(4)
    ) u_ctrl (
        .clk_i(k_clk_i),
        .rst_n_i(k_rst_n),
        .rise_i(ctrl_rise),
        .fall_i(ctrl_fall),
        .q_o(ctrl_q)
    );

    assign read_data_oe_o = ctrl_q[3]; // [R05]
    assign read_valid_flag_o = ctrl_q[2]; // [R09]
    assign echo_strobe_o = ctrl_q[1]; // [R12]
    assign echo_strobe_inverse_o = ctrl_q[0]; // [R12]

    // burst activity seen from the user clock
    always_ff @(posedge k_clk_i or negedge k_rst_n) begin
        if (!k_rst_n) begin
            k_active <= 1'b0;
        end else begin
            k_active <= (slot_ph[0] != ph_idle) || (slot_ph[1] != ph_idle);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_meta <= 1'b0;
            burst_active_o <= 1'b0;
        end else begin
            act_meta <= k_active;
            burst_active_o <= act_meta;
        end
    end
endmodule

// ### design/ddr_out_cell.sv
// Purpose: double data rate output register pair
// Assumes: both words loaded on the rising edge of clk_i
// Notes: rise word shows while clk_i is high, fall word while it is low
`timescale 1ns/10ps
module ddr_out_cell
    import sram_burst_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] rise_i,
    input wire logic [WIDTH-1:0] fall_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] rise_r;
    logic [WIDTH-1:0] fall_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_r <= '0;
            fall_r <= '0;
        end else begin
            rise_r <= rise_i;
            fall_r <= fall_i;
        end
    end

    assign q_o = clk_i ? rise_r : fall_r;
endmodule

// ### design/load_crossing.sv
// Purpose: toggle handshake carrying one burst from the user clock to the link clock
// Assumes: destination takes the word with dst_take_i while dst_valid_o is high
// Notes: source holds its word stable until the acknowledge returns
`timescale 1ns/10ps
module load_crossing
    import sram_burst_pkg::*;
(
    input wire logic src_clk_i,
    input wire logic src_rst_n_i,
    input wire logic src_valid_i,
    input wire burst_t src_data_i,
    output logic src_ready_o,
    input wire logic dst_clk_i,
    input wire logic dst_rst_n_i,
    input wire logic dst_take_i,
    output logic dst_valid_o,
    output burst_t dst_data_o
);
    logic req_tgl;
    logic ack_tgl;
    logic ack_meta;
    logic ack_sync;
    logic req_meta;
    logic req_sync;
    burst_t hold;

    always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
        if (!src_rst_n_i) begin
            req_tgl <= 1'b0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            src_ready_o <= 1'b0;
            hold <= '0;
        end else begin
            ack_meta <= ack_tgl;
            ack_sync <= ack_meta;
            if (src_valid_i && src_ready_o) begin
                hold <= src_data_i;
                req_tgl <= ~req_tgl;
                src_ready_o <= 1'b0;
            end else if (ack_sync == req_tgl) begin
                src_ready_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
        if (!dst_rst_n_i) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            ack_tgl <= 1'b0;
            dst_valid_o <= 1'b0;
            dst_data_o <= '0;
        end else begin
            req_meta <= req_tgl;
            req_sync <= req_meta;
            if (dst_valid_o && dst_take_i) begin
                ack_tgl <= ~ack_tgl;
                dst_valid_o <= 1'b0;
            end else if (!dst_valid_o && (req_sync != ack_tgl)) begin
                dst_valid_o <= 1'b1;
                dst_data_o <= hold;
            end
        end
    end
endmodule

// ### verif/mem_ctrl_model.sv
// Purpose: behavioural memory controller on the link pins
// Assumes: selects change on k_clk_i fall, write data just after each edge
// Notes: idle address and data lines carry a fresh random pattern each cycle
`timescale 1ns/10ps
module mem_ctrl_model
    import sram_burst_pkg::*;
(
    input wire logic k_clk_i,
    output addr_t address_o,
    output logic read_select_n_o,
    output logic write_select_n_o,
    output word_t write_data_o
);
    logic busy = 1'b0;
    initial begin
        address_o = 17'h0_0000;
        read_select_n_o = 1'b1;
        write_select_n_o = 1'b1;
        write_data_o = 36'h0_0000_0000;
    end
    always @(negedge k_clk_i) begin
        if (!busy) begin
            address_o <= addr_t'($urandom());
            write_data_o <= word_t'({$urandom(), $urandom()});
        end
    end
    task automatic rd(input addr_t a);
        busy = 1'b1;
        @(negedge k_clk_i);
        read_select_n_o = 1'b0;
        address_o = a;
        @(negedge k_clk_i);
    endtask
    task automatic rd_stop();
        read_select_n_o = 1'b1;
        busy = 1'b0;
    endtask
    task automatic wr(input addr_t a, input burst_words_t w);
        busy = 1'b1;
        @(negedge k_clk_i);
        write_select_n_o = 1'b0;
        address_o = a;
        @(negedge k_clk_i);
        write_select_n_o = 1'b1;
        address_o = addr_t'($urandom());
        write_data_o = w[0];
        for (int i = 1; i < BURST_LEN; i++) begin
            @(k_clk_i);
            #1;
            write_data_o = w[i];
        end
        @(negedge k_clk_i);
        #1;
        busy = 1'b0;
    endtask
endmodule

// ### verif/sram_read_port_properties.sv
// Purpose: pin timing checks for the burst-4 read port
// Assumes: complementary clock is the falling edge of k_clk_i
// Notes: read history is kept in helper logic on k_clk_i
`timescale 1ns/10ps
module sram_read_port_checker
    import sram_burst_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic k_clk_i,
    input wire logic read_select_n_i,
    input wire logic pll_disable_n_i,
    input wire logic load_valid_i,
    input wire logic load_ready_o,
    input wire word_t read_data_o,
    input wire logic read_data_oe_o,
    input wire logic read_valid_flag_o,
    input wire logic echo_strobe_o,
    input wire logic echo_strobe_inverse_o
);
    logic [4:0] pipe;
    logic [2:0] rises;
    logic taken;
    assign taken = !read_select_n_i && !pipe[0];
    always_ff @(posedge k_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pipe <= 5'h00;
        end else begin
            pipe <= {pipe[3:0], taken};
        end
    end
    always_ff @(posedge k_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rises <= 3'h0;
        end else if (rises != 3'h5) begin
            rises <= rises + 3'h1;
        end
    end
    property p_valid_high_phase;
        @(negedge k_clk_i) disable iff (!rst_n_i)
        read_valid_flag_o == (pll_disable_n_i ? (pipe[3] | pipe[4]) : (pipe[1] | pipe[2]));
    endproperty
    a_valid_high_phase:
        assert property (p_valid_high_phase) else $error("valid wrong in high phase");
    property p_valid_low_phase;
        @(posedge k_clk_i) disable iff (!rst_n_i)
        read_valid_flag_o == (pll_disable_n_i ? (pipe[2] | pipe[3]) : (pipe[1] | pipe[2]));
    endproperty
    a_valid_low_phase:
        assert property (p_valid_low_phase) else $error("valid wrong in low phase");
    property p_oe_follows_valid;
        @(posedge k_clk_i) disable iff (!rst_n_i) read_data_oe_o == read_valid_flag_o;
    endproperty
    a_oe_follows_valid:
        assert property (p_oe_follows_valid) else $error("output enable differs from valid");
    property p_data_zero_idle;
        @(negedge k_clk_i) disable iff (!rst_n_i) !read_valid_flag_o |-> read_data_o == '0;
    endproperty
    a_data_zero_idle:
        assert property (p_data_zero_idle) else $error("data not cleared after burst");
    property p_echo_low;
        @(posedge k_clk_i) disable iff (!rst_n_i)
        rises == 3'h5 |-> !echo_strobe_o && echo_strobe_inverse_o;
    endproperty
    a_echo_low:
        assert property (p_echo_low) else $error("echo pair wrong in low phase");
    property p_echo_high;
        @(negedge k_clk_i) disable iff (!rst_n_i)
        rises == 3'h5 |-> echo_strobe_o && !echo_strobe_inverse_o;
    endproperty
    a_echo_high:
        assert property (p_echo_high) else $error("echo pair wrong in high phase");
    property p_load_drop;
        @(posedge sys_clk_i) disable iff (!rst_n_i) load_valid_i && load_ready_o |=> !load_ready_o;
    endproperty
    a_load_drop:
        assert property (p_load_drop) else $error("preload ready stays high");
    property p_load_back;
        @(posedge sys_clk_i) disable iff (!rst_n_i) $fell(load_ready_o) |-> ##[1:40] load_ready_o;
    endproperty
    a_load_back:
        assert property (p_load_back) else $error("preload ready never returns");
    c_read_pll_on: cover property (@(posedge k_clk_i) disable iff (!rst_n_i)
        taken && pll_disable_n_i);
    c_read_pll_off: cover property (@(posedge k_clk_i) disable iff (!rst_n_i)
        taken && !pll_disable_n_i);
    c_load: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        load_valid_i && load_ready_o);
endmodule

// ### verif/test_burst4_ddr_sram_read_port.sv
// Purpose: self-checking bench for the burst-4 read port
// Assumes: k_clk_i runs free at 6 ns, user clock at 8 ns
// Notes: a monitor pops one expected word per valid half cycle
`timescale 1ns/10ps
module test_burst4_ddr_sram_read_port
    import sram_burst_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic k_clk_i;
    logic rst_n_i, pll_disable_n_i, load_valid_i, read_select_n_i, write_select_n_i;
    logic load_ready_o, burst_active_o, read_data_oe_o, read_valid_flag_o;
    logic echo_strobe_o, echo_strobe_inverse_o;
    addr_t address_i;
    word_t write_data_i, read_data_o;
    burst_t load_data_i;
    int n_errors = 0;
    int total_checks = 0;
    word_t exp_q[$];
    burst_words_t shadow[addr_t];
    addr_t addrs[4];
    logic act_seen = 1'b0;
    burst4_sram_read_port DUT (.sys_clk_i, .rst_n_i, .k_clk_i, .address_i, .read_select_n_i,
        .write_select_n_i, .write_data_i, .pll_disable_n_i, .load_valid_i, .load_data_i,
        .load_ready_o, .burst_active_o, .read_data_o, .read_data_oe_o, .read_valid_flag_o,
        .echo_strobe_o, .echo_strobe_inverse_o);
    mem_ctrl_model u_ctrl (.k_clk_i, .address_o(address_i), .read_select_n_o(read_select_n_i),
        .write_select_n_o(write_select_n_i), .write_data_o(write_data_i));
    always #4 sys_clk_i = ~sys_clk_i;
    initial begin
        k_clk_i = 1'b0;
        #1.3;
        forever #3 k_clk_i = ~k_clk_i;
    end
    task automatic err(input string m);
        n_errors++;
        $display("ERROR t=%0t %s", $time, m);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(k_clk_i) begin
        #1.5;
        if (read_valid_flag_o !== 1'b0) begin
            total_checks++;
            if (exp_q.size() == 0) begin
                err("unexpected read word");
            end else if (read_data_o !== exp_q.pop_front()) begin
                err("read word mismatch");
            end
        end
    end
    always @(negedge sys_clk_i) begin
        if (burst_active_o === 1'b1) begin
            act_seen = 1'b1;
        end
    end
    function automatic burst_words_t rand_words();
        burst_words_t w;
        for (int i = 0; i < BURST_LEN; i++) begin
            w[i] = word_t'({$urandom(), $urandom()});
        end
        return w;
    endfunction
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge sys_clk_i);
        while (load_ready_o !== 1'b1 && n < 100) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (load_ready_o !== 1'b1) begin
            err("preload ready timeout");
        end
    endtask
    task automatic load_burst(input addr_t a, input burst_words_t w);
        wait_ready();
        load_valid_i = 1'b1;
        load_data_i = {a, w};
        shadow[a] = w;
        @(negedge sys_clk_i);
        load_valid_i = 1'b0;
    endtask
    task automatic read_all();
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < BURST_LEN; j++) begin
                exp_q.push_back(shadow[addrs[i]][j]);
            end
            u_ctrl.rd(addrs[i]);
        end
        u_ctrl.rd_stop();
        repeat (8) @(negedge k_clk_i);
        total_checks++;
        if (exp_q.size() != 0) begin
            err("read words missing");
        end
        total_checks++;
        if (act_seen !== 1'b1) begin
            err("burst activity never seen");
        end
        act_seen = 1'b0;
    endtask
    initial begin
        burst_words_t w;
        rst_n_i = 1'b0;
        pll_disable_n_i = 1'b1;
        load_valid_i = 1'b0;
        load_data_i = '0;
        void'($urandom(80));
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            addrs[i] = addr_t'({$urandom(), 2'(i)});
        end
        addrs[0] = 17'h0_0000;
        addrs[3] = 17'h1_FFFF;
        for (int i = 0; i < 4; i++) begin
            load_burst(addrs[i], rand_words());
        end
        wait_ready();
        repeat (4) @(negedge k_clk_i);
        read_all();
        w = rand_words();
        shadow[addrs[1]] = w;
        u_ctrl.wr(addrs[1], w);
        repeat (2) @(negedge k_clk_i);
        read_all();
        @(negedge sys_clk_i);
        pll_disable_n_i = 1'b0;
        repeat (8) @(negedge k_clk_i);
        read_all();
        @(negedge sys_clk_i);
        pll_disable_n_i = 1'b1;
        repeat (8) @(negedge k_clk_i);
        total_checks++;
        if (burst_active_o !== 1'b0) begin
            err("burst activity stuck high");
        end
        tally_and_finish();
    end
    initial begin
        #30000;
        err("watchdog expired");
        tally_and_finish();
    end
endmodule
bind burst4_sram_read_port sram_read_port_checker u_chk (.sys_clk_i, .rst_n_i, .k_clk_i,
    .read_select_n_i, .pll_disable_n_i, .load_valid_i, .load_ready_o, .read_data_o,
    .read_data_oe_o, .read_valid_flag_o, .echo_strobe_o, .echo_strobe_inverse_o);
